// ===== hdl/stc_regs.svh
// Purpose: Timing counts, thresholds and index constants of the transfer controller
// Assumes: 100 MHz core clock, 100 ms timer tick
// Notes:   Times keep their printed unit; tick and cycle counts derive from them
`ifndef STC_REGS_SVH
`define STC_REGS_SVH

`define CLK_FREQ_HZ     100000000
`define TICK_PERIOD_MS  100
`define TICK_CYCLES     (`CLK_FREQ_HZ / 1000 * `TICK_PERIOD_MS)
`define TICKS_PER_S     (1000 / `TICK_PERIOD_MS)
`define DEB_TIME_MS     10
`define DEB_CYCLES      (`CLK_FREQ_HZ / 1000 * `DEB_TIME_MS)

`define TMR_W           16
`define TMR_START       0
`define TMR_XFER        1
`define TMR_RETX        2
`define TMR_STOP        3

`define START_FIX_S     3
`define XFER_FIX_S      3
`define RETX_FIX_MIN    5
`define STOP_FIX_MIN    5
`define START_MIN_MS    500
`define START_MAX_S     15
`define XFER_MIN_S      2
`define XFER_MAX_S      120
`define RETX_MIN_S      6
`define RETX_MAX_MIN    30
`define STOP_MIN_S      2
`define STOP_MAX_MIN    10

`define PCT_W           7
`define PCT_SCALE       100
`define PICKUP_FIX_PCT  85
`define PICKUP_CAL_PCT  100
`define DROP_FIX_PCT    75
`define PICKUP_MIN_PCT  85
`define PICKUP_MAX_PCT  100
`define DROP_MIN_PCT    75
`define DROP_MAX_PCT    98

`endif

// ===== hdl/stc_pkg.sv
// Purpose: Types shared by the transfer controller files
// Assumes: Nothing
// Notes:   Enum codes are one-hot
package stc_pkg;

  typedef enum logic [3:0] {
    ST_NORM   = 4'h1,
    ST_OPEN_E = 4'h2,
    ST_EMERG  = 4'h4,
    ST_OPEN_N = 4'h8
  } xfer_state_t;

  typedef struct packed {
    logic test_btn;
    logic remote_test;
    logic inst_retx;
    logic load_sel;
    logic auto_retx;
    logic ovr_emerg;
    logic ovr_norm;
    logic cal_sel;
    logic phase3_sel;
  } ctl_t;

  typedef struct packed {
    logic [15:0] start_t;
    logic [15:0] xfer_t;
    logic [15:0] retx_t;
    logic [15:0] stop_t;
  } delay_set_t;

  typedef struct packed {
    logic [6:0] pickup_pct;
    logic [6:0] drop_pct;
  } thr_t;

  typedef struct packed {
    logic norm_avail;
    logic emerg_avail;
    logic norm_conn;
    logic emerg_conn;
  } lamp_t;

endpackage

// ===== hdl/deb_filter.sv
// Purpose: Two-stage synchroniser and stability filter per bit
// Assumes: Output changes only after CYCLES stable samples
// Notes:   Resets to zero on every bit
`timescale 1ns/1ps
`default_nettype none
module deb_filter #(
  parameter int N      = 1,
  parameter int CYCLES = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         en_i,
  input  wire logic [N-1:0] d_i,
  output var  logic [N-1:0] q_o
);
  localparam int CW = $clog2(CYCLES + 1);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      logic          s1_r;
      logic          s2_r;
      logic          q_r;
      logic          q_nxt;
      logic [CW-1:0] cnt_r;
      logic [CW-1:0] cnt_nxt;

      always_comb begin
        q_nxt   = q_r;
        cnt_nxt = cnt_r;
        if (s2_r == q_r) begin
          cnt_nxt = '0;
        end else if (cnt_r == CW'(CYCLES - 1)) begin
          q_nxt   = s2_r;
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end

      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          s1_r  <= 1'b0;
          s2_r  <= 1'b0;
          q_r   <= 1'b0;
          cnt_r <= '0;
        end else if (en_i) begin
          s1_r  <= d_i[g];
          s2_r  <= s1_r;
          q_r   <= q_nxt;
          cnt_r <= cnt_nxt;
        end
      end

      assign q_o[g] = q_r;
    end
  endgenerate
endmodule // deb_filter
`default_nettype wire

// ===== hdl/uv_sense.sv
// Purpose: Undervoltage detector with pickup and dropout hysteresis per channel
// Assumes: Voltage words are percent of nominal
// Notes:   Dropout level is pickup times dropout percent, compared without division
`timescale 1ns/1ps
`default_nettype none
`include "stc_regs.svh"
module uv_sense #(
  parameter int N = 4
) (
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  input  wire logic                   en_i,
  input  wire logic [N-1:0][7:0]      volt_i,
  input  wire logic [`PCT_W-1:0]      pickup_i,
  input  wire logic [`PCT_W-1:0]      drop_i,
  output var  logic [N-1:0]           ok_o
);
  logic [15:0] drop_lvl;

  // Widen before multiplying so the product is not cut to the operand width
  assign drop_lvl = 16'(pickup_i) * 16'(drop_i);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      logic        ok_r;
      logic        ok_nxt;
      logic [15:0] v_scaled;

      assign v_scaled = 16'(volt_i[g]) * 16'(`PCT_SCALE);

      // Held source drops out only below the dropout level
      always_comb begin
        if (ok_r) begin
          ok_nxt = (v_scaled >= drop_lvl);
        end else begin
          ok_nxt = (volt_i[g] >= 8'(pickup_i));
        end
      end

      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          ok_r <= 1'b0;
        end else if (en_i) begin
          ok_r <= ok_nxt;
        end
      end

      assign ok_o[g] = ok_r;
    end
  endgenerate
endmodule // uv_sense
`default_nettype wire

// ===== hdl/source_transfer_controller.sv
// Purpose: Sequences load transfer between utility and generator sources
// Assumes: Inputs synchronous to core_clk_i; volt_i channels 0-2 utility, 3 generator
// Notes:   ADJUSTABLE selects the adjustable variant; delays are in 100 ms ticks
`timescale 1ns/1ps
`default_nettype none
`include "stc_regs.svh"
// Overview of operation
// - Available lamps follow each source independently
// - Connected lamps from position, at most one
// - Test runs generator; loads it if selected
// - Instant retransfer skips running retransfer delay
// - Override emergency closes generator when available
// - Override normal closes utility when available
// - Manual mode blocks automatic retransfer
// - Generator failure forces retransfer unless override emergency is set
// - No-load test runs generator without load
// - Fixed variant pickup 85 or 100 percent
// - Adjustable variant three or single phase
// - Start delay from utility loss
// - Transfer delay from generator ready
// - Retransfer delay from utility return
// - Stop delay after load returns
// - Phases monitored depend on variant
// - Utility undervoltage drives the timing sequence
// - Pickup and dropout hysteresis per variant
// - Remote test acts like test input
module source_transfer_controller
  import stc_pkg::*;
#(
  parameter bit ADJUSTABLE  = 1'b0,
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int DEB_CYCLES  = `DEB_CYCLES
) (
  input  wire logic             core_clk_i,
  input  wire logic             rstn_i,
  input  wire logic             ce_i,
  input  wire ctl_t             ctl_i,
  input  wire logic [3:0][7:0]  volt_i,
  input  wire logic             gen_freq_ok_i,
  input  wire logic             pos_norm_i,
  input  wire logic             pos_emerg_i,
  input  wire delay_set_t       dly_i,
  input  wire thr_t             thr_i,
  output var  logic             gen_run_o,
  output var  logic             close_norm_o,
  output var  logic             close_emerg_o,
  output var  lamp_t            lamps_o,
  output var  xfer_state_t      state_o
);
  localparam int TW = `TMR_W;
  localparam int PW = $clog2(TICK_CYCLES);

  localparam logic [TW-1:0] START_FIX = TW'(`START_FIX_S * `TICKS_PER_S);
  localparam logic [TW-1:0] XFER_FIX  = TW'(`XFER_FIX_S * `TICKS_PER_S);
  localparam logic [TW-1:0] RETX_FIX  = TW'(`RETX_FIX_MIN * 60 * `TICKS_PER_S);
  localparam logic [TW-1:0] STOP_FIX  = TW'(`STOP_FIX_MIN * 60 * `TICKS_PER_S);
  localparam logic [TW-1:0] START_MIN = TW'((`START_MIN_MS + `TICK_PERIOD_MS - 1)
                                            / `TICK_PERIOD_MS);
  localparam logic [TW-1:0] START_MAX = TW'(`START_MAX_S * `TICKS_PER_S);
  localparam logic [TW-1:0] XFER_MIN  = TW'(`XFER_MIN_S * `TICKS_PER_S);
  localparam logic [TW-1:0] XFER_MAX  = TW'(`XFER_MAX_S * `TICKS_PER_S);
  localparam logic [TW-1:0] RETX_MIN  = TW'(`RETX_MIN_S * `TICKS_PER_S);
  localparam logic [TW-1:0] RETX_MAX  = TW'(`RETX_MAX_MIN * 60 * `TICKS_PER_S);
  localparam logic [TW-1:0] STOP_MIN  = TW'(`STOP_MIN_S * `TICKS_PER_S);
  localparam logic [TW-1:0] STOP_MAX  = TW'(`STOP_MAX_MIN * 60 * `TICKS_PER_S);

  function automatic logic [TW-1:0] clamp(input logic [TW-1:0] v,
                                          input logic [TW-1:0] lo,
                                          input logic [TW-1:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  // Input conditioning
  ctl_t                c;
  logic [3:0]          uv_ok;
  logic [6:0]          sense_q;
  logic [`PCT_W-1:0]   pickup;
  logic [`PCT_W-1:0]   drop;

  deb_filter #(.N($bits(ctl_t)), .CYCLES(DEB_CYCLES)) u_ctl_deb (
    .clk_i  (core_clk_i),
    .rstn_i (rstn_i),
    .en_i   (ce_i),
    .d_i    (ctl_i),
    .q_o    (c)
  );

  always_comb begin
    if (ADJUSTABLE) begin
      pickup = `PCT_W'(clamp(TW'(thr_i.pickup_pct), TW'(`PICKUP_MIN_PCT),
                             TW'(`PICKUP_MAX_PCT)));
      drop   = `PCT_W'(clamp(TW'(thr_i.drop_pct), TW'(`DROP_MIN_PCT),
                             TW'(`DROP_MAX_PCT)));
    end else begin
      pickup = c.cal_sel ? `PCT_W'(`PICKUP_CAL_PCT) : `PCT_W'(`PICKUP_FIX_PCT);
      drop   = `PCT_W'(`DROP_FIX_PCT);
    end
  end

  uv_sense #(.N(4)) u_sense (
    .clk_i    (core_clk_i),
    .rstn_i   (rstn_i),
    .en_i     (ce_i),
    .volt_i   (volt_i),
    .pickup_i (pickup),
    .drop_i   (drop),
    .ok_o     (uv_ok)
  );

  deb_filter #(.N(7), .CYCLES(DEB_CYCLES)) u_sense_deb (
    .clk_i  (core_clk_i),
    .rstn_i (rstn_i),
    .en_i   (ce_i),
    .d_i    ({pos_emerg_i, pos_norm_i, gen_freq_ok_i, uv_ok}),
    .q_o    (sense_q)
  );

  logic n_ok;
  logic e_ok;
  logic pos_n;
  logic pos_e;
  logic test_act;
  logic test_load;
  logic ovr_auto;

  always_comb begin
    if (ADJUSTABLE) begin
      n_ok = c.phase3_sel ? &sense_q[2:0] : sense_q[0];
    end else begin
      n_ok = sense_q[0];
    end
  end

  assign e_ok      = sense_q[3] & sense_q[4];
  assign pos_n     = sense_q[5];
  assign pos_e     = sense_q[6];
  assign test_act  = c.test_btn | c.remote_test;
  assign test_load = test_act & c.load_sel;
  assign ovr_auto  = !c.ovr_emerg && !c.ovr_norm;

  // Shared tick prescaler
  logic [PW-1:0] pre_r;
  logic [PW-1:0] pre_nxt;
  logic          tick_r;
  logic          tick_nxt;

  always_comb begin
    tick_nxt = (pre_r == PW'(TICK_CYCLES - 1));
    pre_nxt  = tick_nxt ? '0 : pre_r + 1'b1;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pre_r  <= '0;
      tick_r <= 1'b0;
    end else if (ce_i) begin
      pre_r  <= pre_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Delay timers
  xfer_state_t   state_r;
  xfer_state_t   state_nxt;
  logic          gen_run_r;
  logic          gen_run_nxt;
  logic [3:0]    tmr_run;
  logic [3:0]    tmr_done;
  logic [TW-1:0] tmr_lim [4];
  logic          start_done;
  logic          need_gen;
  logic          need_load;

  always_comb begin
    if (ADJUSTABLE) begin
      tmr_lim[`TMR_START] = clamp(dly_i.start_t, START_MIN, START_MAX);
      tmr_lim[`TMR_XFER]  = clamp(dly_i.xfer_t, XFER_MIN, XFER_MAX);
      tmr_lim[`TMR_RETX]  = clamp(dly_i.retx_t, RETX_MIN, RETX_MAX);
      tmr_lim[`TMR_STOP]  = clamp(dly_i.stop_t, STOP_MIN, STOP_MAX);
    end else begin
      tmr_lim[`TMR_START] = START_FIX;
      tmr_lim[`TMR_XFER]  = XFER_FIX;
      tmr_lim[`TMR_RETX]  = RETX_FIX;
      tmr_lim[`TMR_STOP]  = STOP_FIX;
    end
  end

  assign start_done = tmr_done[`TMR_START];
  assign need_gen   = start_done | test_act;
  assign need_load  = start_done | test_load;

  always_comb begin
    tmr_run[`TMR_START] = !n_ok;
    tmr_run[`TMR_XFER]  = (state_r == ST_NORM) && gen_run_r && e_ok
                          && need_load && ovr_auto;
    tmr_run[`TMR_RETX]  = (state_r == ST_EMERG) && n_ok && !test_load;
    tmr_run[`TMR_STOP]  = (state_r == ST_NORM) && gen_run_r && !need_gen;
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_tmr
      logic [TW-1:0] cnt_r;
      logic [TW-1:0] cnt_nxt;

      always_comb begin
        if (!tmr_run[g]) begin
          cnt_nxt = '0;
        end else if (tick_r && (cnt_r < tmr_lim[g])) begin
          cnt_nxt = cnt_r + 1'b1;
        end else begin
          cnt_nxt = cnt_r;
        end
      end

      always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
          cnt_r <= '0;
        end else if (ce_i) begin
          cnt_r <= cnt_nxt;
        end
      end

      assign tmr_done[g] = tmr_run[g] && (cnt_r >= tmr_lim[g]);
    end
  endgenerate

  // Transfer sequencer
  logic retx_go;

  always_comb begin
    retx_go = (c.ovr_norm && n_ok)
              || (!c.ovr_emerg && ((c.inst_retx && n_ok)
                                   || !e_ok
                                   || (tmr_done[`TMR_RETX] && c.auto_retx)));
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_NORM: begin
        if ((c.ovr_emerg && e_ok) || (ovr_auto && tmr_done[`TMR_XFER])) begin
          state_nxt = ST_OPEN_E;
        end
      end
      ST_OPEN_E: begin
        if (!e_ok || (c.ovr_norm && n_ok)) begin
          state_nxt = ST_OPEN_N;
        end else if (!pos_n && !pos_e) begin
          state_nxt = ST_EMERG;
        end
      end
      ST_EMERG: begin
        if (retx_go) begin
          state_nxt = ST_OPEN_N;
        end
      end
      ST_OPEN_N: begin
        if (c.ovr_emerg && e_ok) begin
          state_nxt = ST_OPEN_E;
        end else if (!pos_n && !pos_e) begin
          state_nxt = ST_NORM;
        end
      end
      default: begin
        state_nxt = ST_OPEN_N;
      end
    endcase
  end

  always_comb begin
    gen_run_nxt = gen_run_r;
    if (need_gen || (state_r != ST_NORM)) begin
      gen_run_nxt = 1'b1;
    end else if (tmr_done[`TMR_STOP]) begin
      gen_run_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_r       <= ST_NORM;
      gen_run_r     <= 1'b0;
      close_norm_o  <= 1'b0;
      close_emerg_o <= 1'b0;
      lamps_o       <= '0;
    end else if (ce_i) begin
      state_r       <= state_nxt;
      gen_run_r     <= gen_run_nxt;
      close_norm_o  <= (state_nxt == ST_NORM);
      close_emerg_o <= (state_nxt == ST_EMERG);
      lamps_o.norm_avail  <= n_ok;
      lamps_o.emerg_avail <= e_ok;
      lamps_o.norm_conn   <= pos_n && !pos_e;
      lamps_o.emerg_conn  <= pos_e && !pos_n;
    end
  end

  assign gen_run_o = gen_run_r;
  assign state_o   = state_r;
endmodule // source_transfer_controller
`default_nettype wire

// ===== sim/source_transfer_controller_properties.sv
// Purpose: Port-level properties of the transfer controller
// Assumes: Adjustable delays of 5, 20, 60 and 20 ticks of 10 cycles
// Notes:   Counters hold how long the utility lamp has kept its level and how long the generator lamp has stayed lit
`timescale 1ns/1ps
`default_nettype none
module stc_checker
  import stc_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire ctl_t        ctl_i,
  input  wire logic        gen_freq_ok_i,
  input  wire logic        pos_norm_i,
  input  wire logic        gen_run_o,
  input  wire logic        close_norm_o,
  input  wire logic        close_emerg_o,
  input  wire lamp_t       lamps_o,
  input  wire xfer_state_t state_o
);
  int        nlo_r;
  int        nhi_r;
  int        ehi_r;
  wire logic tst = ctl_i.test_btn | ctl_i.remote_test;
  always_ff @(posedge core_clk_i) begin
    nlo_r <= (!rstn_i || lamps_o.norm_avail) ? 0 : nlo_r + 1;
    nhi_r <= (!rstn_i || !lamps_o.norm_avail) ? 0 : nhi_r + 1;
    ehi_r <= (!rstn_i || !lamps_o.emerg_avail) ? 0 : ehi_r + 1;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_cmd_excl; !(close_norm_o && close_emerg_o); endproperty
  a_cmd_excl: assert property (p_cmd_excl) else $error("both close commands high");
  property p_conn_excl; !(lamps_o.norm_conn && lamps_o.emerg_conn); endproperty
  a_conn_excl: assert property (p_conn_excl) else $error("both connected lamps lit");
  property p_bbm; $rose(close_emerg_o) |-> !pos_norm_i && !$past(close_norm_o, 2); endproperty
  a_bbm: assert property (p_bbm) else $error("emergency close without open");
  property p_start; $rose(gen_run_o) && !tst |-> nlo_r >= 35; endproperty
  a_start: assert property (p_start) else $error("start delay too short");
  property p_xfer; $rose(close_emerg_o) && !ctl_i.ovr_emerg |-> ehi_r >= 180; endproperty
  a_xfer: assert property (p_xfer) else $error("transfer delay too short");
  property p_retx;
    $fell(close_emerg_o) && !ctl_i.inst_retx && !ctl_i.ovr_norm && gen_freq_ok_i
      |-> nhi_r >= 580;
  endproperty
  a_retx: assert property (p_retx) else $error("retransfer delay too short");
  property p_stop; $fell(gen_run_o) |-> state_o == ST_NORM && close_norm_o; endproperty
  a_stop: assert property (p_stop) else $error("stop away from utility");
  property p_ovr_e;
    ctl_i.ovr_emerg && lamps_o.emerg_avail && state_o == ST_NORM |-> ##[1:30] state_o != ST_NORM;
  endproperty
  a_ovr_e: assert property (p_ovr_e) else $error("emergency override ignored");
  property p_ovr_n;
    ctl_i.ovr_norm && lamps_o.norm_avail && state_o == ST_EMERG |-> ##[1:30] state_o != ST_EMERG;
  endproperty
  a_ovr_n: assert property (p_ovr_n) else $error("normal override ignored");
  property p_inst;
    ctl_i.inst_retx && lamps_o.norm_avail && state_o == ST_EMERG |-> ##[1:30] state_o != ST_EMERG;
  endproperty
  a_inst: assert property (p_inst) else $error("instant retransfer ignored");
  property p_manual;
    !ctl_i.auto_retx && !ctl_i.inst_retx && !ctl_i.ovr_norm && gen_freq_ok_i
      && state_o == ST_EMERG |=> state_o == ST_EMERG;
  endproperty
  a_manual: assert property (p_manual) else $error("retransfer in manual mode");
  property p_gen_fail;
    $fell(gen_freq_ok_i) && state_o == ST_EMERG && !ctl_i.ovr_emerg |-> ##[1:40] state_o != ST_EMERG;
  endproperty
  a_gen_fail: assert property (p_gen_fail) else $error("generator loss ignored");
  property p_test; $rose(tst) |-> ##[1:20] gen_run_o; endproperty
  a_test: assert property (p_test) else $error("test did not start generator");
  property p_noload;
    tst && !ctl_i.load_sel && !ctl_i.ovr_emerg && lamps_o.norm_avail && state_o == ST_NORM
      |=> state_o == ST_NORM;
  endproperty
  a_noload: assert property (p_noload) else $error("no-load test moved load");
endmodule // stc_checker
`default_nettype wire

// ===== sim/gen_contact_model.sv
// Purpose: Generator set and transfer contact assembly at the far side
// Assumes: Generator is ready SPIN cycles after run; contacts travel TRAVEL cycles
// Notes:   Interlock keeps the two contacts from both reading closed
`timescale 1ns/1ps
`default_nettype none
module gen_contact_model #(
  parameter int SPIN   = 20,
  parameter int TRAVEL = 3
) (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       run_i,
  input  wire logic       fail_i,
  input  wire logic       close_norm_i,
  input  wire logic       close_emerg_i,
  output var  logic [7:0] volt_o,
  output var  logic       freq_ok_o,
  output var  logic       pos_norm_o,
  output var  logic       pos_emerg_o
);
  int spin_r;
  int tn_r;
  int te_r;
  always_ff @(posedge clk_i) begin
    spin_r      <= (!rstn_i || !run_i) ? 0 : spin_r + 1;
    tn_r        <= (!rstn_i || !close_norm_i || pos_norm_o) ? 0 : tn_r + 1;
    te_r        <= (!rstn_i || !close_emerg_i || pos_emerg_o) ? 0 : te_r + 1;
    freq_ok_o   <= rstn_i && run_i && !fail_i && spin_r >= SPIN;
    pos_norm_o  <= rstn_i && close_norm_i && (pos_norm_o || (tn_r >= TRAVEL && !pos_emerg_o));
    pos_emerg_o <= rstn_i && close_emerg_i && (pos_emerg_o || (te_r >= TRAVEL && !pos_norm_o));
  end
  assign volt_o = freq_ok_o ? 8'h64 : 8'h00;
endmodule // gen_contact_model
`default_nettype wire

// ===== sim/source_transfer_controller_tb_top.sv
// Purpose: Self-checking bench for the transfer controller
// Assumes: Adjustable variant, 10-cycle tick, 2-cycle debounce
// Notes:   cmd packs run, close normal and close emergency for compact compares
`timescale 1ns/1ps
`default_nettype none
module source_transfer_controller_tb_top
  import stc_pkg::*;
;
  logic                 core_clk;
  logic                 rstn;
  logic                 fail;
  logic                 ce;
  thr_t                 thr;
  ctl_t                 ctl;
  logic [2:0][7:0]      uv;
  logic [7:0]           gv;
  logic                 fok, pn, pe, run, cn, cem;
  lamp_t                lamps;
  xfer_state_t          st;
  int                   miscompares = 0;
  int                   num_checks = 0;
  wire logic [3:0][7:0] volt = {gv, uv};
  wire logic [3:0]      cmd = {1'b0, run, cn, cem};
  logic [7:0]           hv [4] = '{8'h46, 8'h3C, 8'h46, 8'h64};

  source_transfer_controller #(.ADJUSTABLE(1'b1), .TICK_CYCLES(10), .DEB_CYCLES(2)) uut (
    .core_clk_i(core_clk), .rstn_i(rstn), .ce_i(ce), .ctl_i(ctl), .volt_i(volt),
    .gen_freq_ok_i(fok), .pos_norm_i(pn), .pos_emerg_i(pe),
    .dly_i({16'h0005, 16'h0014, 16'h003C, 16'h0014}), .thr_i(thr),
    .gen_run_o(run), .close_norm_o(cn), .close_emerg_o(cem), .lamps_o(lamps), .state_o(st));
  gen_contact_model #(.SPIN(20), .TRAVEL(3)) gen (
    .clk_i(core_clk), .rstn_i(rstn), .run_i(run), .fail_i(fail), .close_norm_i(cn),
    .close_emerg_i(cem), .volt_o(gv), .freq_ok_o(fok), .pos_norm_o(pn), .pos_emerg_o(pe));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(logic [3:0] got, logic [3:0] exp);
    #1;
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits a bounded time for the state or the command bits, then compares
  task automatic wt(bit r, logic [3:0] exp, int lim);
    int n;
    n = 0;
    while ((r ? cmd : st) !== exp && n < lim) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(r ? cmd : st, exp);
  endtask
  task automatic outage();
    cyc(1);
    uv[0] <= 8'h1E;
    wt(0, ST_EMERG, 600);
    cyc(1);
    uv[0] <= 8'h64;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end

  initial begin
    rstn = 1'b0;
    fail = 1'b0;
    ce = 1'b1;
    thr = {7'h55, 7'h4B};
    ctl = '0;
    ctl.auto_retx = 1'b1;
    ctl.phase3_sel = 1'b1;
    uv = {3{8'h64}};
    cyc(5);
    rstn <= 1'b1;
    cyc(20);
    chk(cmd, 4'b0010);
    chk(lamps, 4'b1010);
    // Clock enable low freezes all state, so a long outage goes unseen
    ce <= 1'b0;
    uv[0] <= 8'h1E;
    cyc(100);
    chk(lamps, 4'b1010);
    chk(cmd, 4'b0010);
    uv[0] <= 8'h64;
    cyc(1);
    ce <= 1'b1;
    cyc(20);
    chk(lamps, 4'b1010);
    // Phase C alone crosses dropout and pickup; the dip is shorter than the start delay
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      uv[2] <= hv[i];
      cyc(10);
      chk(lamps.norm_avail, 4'(i == 0 || i == 3));
    end
    cyc(40);
    chk(cmd, 4'b0010);
    $display("test hysteresis done");
    outage();
    cyc(300);
    chk(lamps, 4'b1101);
    wt(0, ST_NORM, 700);
    cyc(20);
    chk(cmd, 4'b0110);
    wt(1, 4'b0010, 300);
    $display("test outage done");
    outage();
    cyc(100);
    ctl.inst_retx <= 1'b1;
    wt(0, ST_NORM, 60);
    cyc(1);
    ctl.inst_retx <= 1'b0;
    wt(1, 4'b0010, 300);
    $display("test instant done");
    cyc(1);
    ctl.auto_retx <= 1'b0;
    outage();
    cyc(800);
    chk(lamps, 4'b1101);
    cyc(1);
    fail <= 1'b1;
    wt(0, ST_NORM, 60);
    cyc(1);
    fail <= 1'b0;
    ctl.auto_retx <= 1'b1;
    wt(1, 4'b0010, 300);
    $display("test manual done");
    cyc(1);
    ctl.test_btn <= 1'b1;
    wt(1, 4'b0110, 20);
    cyc(300);
    chk(st, ST_NORM);
    cyc(1);
    ctl.ovr_emerg <= 1'b1;
    wt(0, ST_EMERG, 60);
    cyc(1);
    ctl.ovr_emerg <= 1'b0;
    ctl.ovr_norm <= 1'b1;
    wt(0, ST_NORM, 60);
    cyc(1);
    ctl.ovr_norm <= 1'b0;
    ctl.test_btn <= 1'b0;
    wt(1, 4'b0010, 300);
    $display("test override done");
    cyc(1);
    ctl.load_sel <= 1'b1;
    cyc(10);
    ctl.remote_test <= 1'b1;
    wt(1, 4'b0110, 20);
    wt(0, ST_EMERG, 400);
    cyc(1);
    ctl.remote_test <= 1'b0;
    wt(0, ST_NORM, 800);
    wt(1, 4'b0010, 300);
    $display("test remote done");
    // Mid-run reset clears every command, then utility closes again
    cyc(1);
    rstn <= 1'b0;
    cyc(2);
    chk(cmd, 4'b0000);
    cyc(1);
    rstn <= 1'b1;
    cyc(20);
    chk(cmd, 4'b0010);
    chk(lamps, 4'b1010);
    $display("test reset done");
    summarize();
  end
endmodule // source_transfer_controller_tb_top

bind source_transfer_controller stc_checker u_props (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .ctl_i(ctl_i), .gen_freq_ok_i(gen_freq_ok_i),
  .pos_norm_i(pos_norm_i), .gen_run_o(gen_run_o), .close_norm_o(close_norm_o),
  .close_emerg_o(close_emerg_o), .lamps_o(lamps_o), .state_o(state_o));
`default_nettype wire
